// ==== inc/external_memory_if_pkg.sv ====
package external_memory_if_pkg;
   // Register offsets on the bus (byte addresses, not all word aligned)
   localparam logic [7:0] PAGE_OFFSET = 8'hAA;
   localparam logic [7:0] CONFIG_OFFSET = 8'hC7;
   localparam logic [7:0] PORT_OUT_OFFSET = 8'hD0;
   localparam logic [7:0] PORT_OUT_OFFSET2 = 8'hD4;
   localparam logic [7:0] STATUS_OFFSET = 8'hD8;
   // Reset values
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [4:0] CONFIG_RESET = 5'h03;
   localparam logic [7:0] LATCH_RESET = 8'hFF;
   // Configuration field positions
   localparam int BUS_STYLE_BIT = 4;
   localparam int MODE_HI_BIT = 3;
   localparam int MODE_LO_BIT = 2;
   localparam int WIDTH_HI_BIT = 1;
   // Memory modes
   localparam logic [1:0] MODE_ONCHIP = 2'h0;
   localparam logic [1:0] MODE_SPLIT_NOBANK = 2'h1;
   localparam logic [1:0] MODE_SPLIT_BANK = 2'h2;
   localparam logic [1:0] MODE_OFFCHIP = 2'h3;
   // On-chip space: 1k boundary, in pages
   localparam logic [7:0] ONCHIP_PAGES = 8'h04;
   localparam int ONCHIP_AW = 10;
   // Fixed strobe width of the data phase
   localparam logic [3:0] STROBE_CYCLES = 4'h1;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ALE_HI, ST_ALE_LO, ST_STROBE, ST_DONE
   } state_type;
endpackage : external_memory_if_pkg

// ==== hw/external_memory_if.sv ====
`timescale 1ns/1ps
`default_nettype none
module external_memory_if
   import external_memory_if_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // CPU move request
   input wire logic move_req,
   input wire logic move_write,
   input wire logic move_wide,
   input wire logic [15:0] move_addr,
   input wire logic [7:0] move_wdata,
   output logic move_done,
   output logic [7:0] move_rdata,
   // Port 1 (data / shared address-data)
   input wire logic [7:0] p1_in,
   output logic [7:0] p1_out,
   output logic [7:0] p1_oe,
   // Port 2 (low address, split style)
   output logic [7:0] p2_out,
   output logic [7:0] p2_oe,
   // Ports 3.4-4.3 (high address)
   output logic [7:0] phi_out,
   output logic [7:0] phi_oe,
   // Strobes: latch strobe high active, read/write low active
   output logic latch_strobe,
   output logic rd_b,
   output logic wr_b,
   output logic strobe_oe,
   output logic pins_claimed
);
   localparam logic [31:0] ZERO32 = 32'h0000_0000;

   // On-chip data RAM
   logic [7:0] onchip_mem [0:(1<<ONCHIP_AW)-1];

   logic [7:0] page_reg, page_next;
   logic [4:0] cfg_reg, cfg_next;
   logic [7:0] p1_latch_reg, p2_latch_reg, phi_latch_reg;
   logic [7:0] p1_sync1_reg, p1_sync2_reg;
   state_type state_reg, state_next;
   logic [1:0] cnt_reg, cnt_next;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic write_reg;
   logic drive_hi_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic done_reg;
   logic [7:0] mrdata_reg;
   logic [7:0] p1_out_reg, p1_oe_reg, p2_out_reg, p2_oe_reg;
   logic [7:0] phi_out_reg, phi_oe_reg;
   logic ale_reg, rd_b_reg, wr_b_reg, soe_reg, claim_reg;
   logic [1:0] rd_pipe_reg;

   // Address decode
   wire logic bus_req = avs_read | avs_write;
   wire logic sel_page = avs_address == PAGE_OFFSET;
   wire logic sel_cfg = avs_address == CONFIG_OFFSET;
   wire logic sel_p1 = avs_address == PORT_OUT_OFFSET;
   wire logic sel_p2 = avs_address == PORT_OUT_OFFSET2;
   wire logic sel_stat = avs_address == STATUS_OFFSET;
   wire logic wr_go = avs_write & ack_reg; // Lands at the acknowledge edge

   // Configuration fields
   wire logic split_style = cfg_reg[BUS_STYLE_BIT];
   wire logic [1:0] mem_mode = cfg_reg[MODE_HI_BIT:MODE_LO_BIT];
   wire logic [1:0] ale_width = cfg_reg[WIDTH_HI_BIT:0];

   // Effective address: 8-bit moves take high byte from page
   wire logic [15:0] eff_addr = move_wide ? move_addr
                              : {page_reg, move_addr[7:0]};
   wire logic below_1k = eff_addr[15:8] < ONCHIP_PAGES;
   wire logic go_off = (mem_mode == MODE_OFFCHIP)
                     | ((mem_mode == MODE_SPLIT_NOBANK
                        | mem_mode == MODE_SPLIT_BANK) & ~below_1k);
   // High byte driven unless no-bank 8-bit or off-only 8-bit
   wire logic hi_driven = move_wide | (mem_mode == MODE_SPLIT_BANK);
   wire logic start = move_req & (state_reg == ST_IDLE);
   wire logic [ONCHIP_AW-1:0] ram_idx = eff_addr[ONCHIP_AW-1:0];

   // Bus reads show own state
   wire logic [31:0] rd_mux =
      sel_page ? {24'h000000, page_reg}
      : sel_cfg ? {27'h0000000, cfg_reg}
      : sel_p1 ? {16'h0000, phi_latch_reg, p1_latch_reg}
      : sel_p2 ? {24'h000000, p2_latch_reg}
      : sel_stat ? {29'h00000000, 1'b0, claim_reg,
                    state_reg != ST_IDLE}
      : ZERO32;

   // Register writes; unmapped writes are accepted and dropped
   always_comb begin
      page_next = page_reg;
      cfg_next = cfg_reg;
      if (wr_go && sel_page) begin
         page_next = avs_writedata[7:0];
      end
      if (wr_go && sel_cfg) begin
         cfg_next = avs_writedata[4:0];
      end
   end

   // One wait state, then acknowledge
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
         rdata_reg <= ZERO32;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
         rdata_reg <= rd_mux;
      end
   end

   // Software registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         page_reg <= PAGE_RESET;
         cfg_reg <= CONFIG_RESET;
         p1_latch_reg <= LATCH_RESET;
         p2_latch_reg <= LATCH_RESET;
         phi_latch_reg <= LATCH_RESET;
      end else begin
         page_reg <= page_next;
         cfg_reg <= cfg_next;
         if (wr_go && sel_p1) begin
            p1_latch_reg <= avs_writedata[7:0];
            phi_latch_reg <= avs_writedata[15:8];
         end
         if (wr_go && sel_p2) begin
            p2_latch_reg <= avs_writedata[7:0];
         end
      end
   end

   // Pin input synchroniser
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         p1_sync1_reg <= 8'h00;
         p1_sync2_reg <= 8'h00;
      end else begin
         p1_sync1_reg <= p1_in;
         p1_sync2_reg <= p1_sync1_reg;
      end
   end

   // Transaction sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start && go_off) begin
               state_next = split_style ? ST_STROBE : ST_ALE_HI;
               cnt_next = split_style ? 2'h0 : ale_width;
            end
         end
         ST_ALE_HI: begin
            if (cnt_reg == 2'h0) begin
               state_next = ST_ALE_LO;
               cnt_next = ale_width;
            end else begin
               cnt_next = cnt_reg - 2'h1;
            end
         end
         ST_ALE_LO: begin
            if (cnt_reg == 2'h0) begin
               state_next = ST_STROBE;
               cnt_next = 2'(STROBE_CYCLES - 4'h1);
            end else begin
               cnt_next = cnt_reg - 2'h1;
            end
         end
         ST_STROBE: begin
            if (cnt_reg == 2'h0) begin
               state_next = ST_DONE;
            end else begin
               cnt_next = cnt_reg - 2'h1;
            end
         end
         ST_DONE: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Capture the move and step the sequencer
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 2'h0;
         addr_reg <= 16'h0000;
         wdata_reg <= 8'h00;
         write_reg <= 1'b0;
         drive_hi_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         if (start) begin
            addr_reg <= eff_addr;
            wdata_reg <= move_wdata;
            write_reg <= move_write;
            drive_hi_reg <= hi_driven;
         end
      end
   end

   // On-chip access completes in one cycle
   always_ff @(posedge sys_clk) begin
      if (start && !go_off && move_write) begin
         onchip_mem[ram_idx] <= move_wdata;
      end
   end

   // Completion and read data; off-chip read data crosses the two pin
   // flops, so a read finishes two cycles after its strobe ends
   wire logic strobe_end = state_reg == ST_STROBE && cnt_reg == 2'h0;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         done_reg <= 1'b0;
         mrdata_reg <= 8'h00;
         rd_pipe_reg <= 2'h0;
      end else begin
         rd_pipe_reg <= {rd_pipe_reg[0], strobe_end & ~write_reg};
         done_reg <= (start & ~go_off) | (strobe_end & write_reg)
                     | rd_pipe_reg[1];
         if (start && !go_off) begin
            mrdata_reg <= onchip_mem[ram_idx];
         end else if (rd_pipe_reg[1]) begin
            mrdata_reg <= p1_sync2_reg;
         end
      end
   end

   // Pin values: latches outside moves and on pins a move leaves unused, interface values on the rest
   wire logic active = state_next != ST_IDLE && state_next != ST_DONE;
   wire logic addr_ph = state_next == ST_ALE_HI;
   wire logic data_ph = state_next == ST_ALE_LO | state_next == ST_STROBE;
   wire logic [15:0] a_now = start ? eff_addr : addr_reg;
   wire logic [7:0] d_now = start ? move_wdata : wdata_reg;
   wire logic wr_now = start ? move_write : write_reg;
   wire logic hi_now = start ? hi_driven : drive_hi_reg;
   wire logic sp = split_style;
   wire logic [7:0] p1_val = !active ? p1_latch_reg
                           : (!sp && addr_ph) ? a_now[7:0] : d_now;
   wire logic p1_drv = !active | (!sp & addr_ph) | (data_ph & wr_now)
                     | (sp & wr_now);
   wire logic [7:0] hi_val = (active && hi_now) ? a_now[15:8]
                           : phi_latch_reg;
   wire logic [7:0] p2_val = (active && sp) ? a_now[7:0] : p2_latch_reg;

   // Output flops; output mode (open-drain/push-pull) is outside here
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         p1_out_reg <= LATCH_RESET;
         p1_oe_reg <= 8'hFF;
         p2_out_reg <= LATCH_RESET;
         p2_oe_reg <= 8'hFF;
         phi_out_reg <= LATCH_RESET;
         phi_oe_reg <= 8'hFF;
         ale_reg <= 1'b0;
         rd_b_reg <= 1'b1;
         wr_b_reg <= 1'b1;
         soe_reg <= 1'b0;
         claim_reg <= 1'b0;
      end else begin
         p1_out_reg <= p1_val;
         p1_oe_reg <= {8{p1_drv}};
         p2_out_reg <= p2_val;
         p2_oe_reg <= 8'hFF;
         phi_out_reg <= hi_val;
         phi_oe_reg <= 8'hFF;
         ale_reg <= active & addr_ph;
         rd_b_reg <= ~(state_next == ST_STROBE & ~wr_now);
         wr_b_reg <= ~(state_next == ST_STROBE & wr_now);
         soe_reg <= active;
         claim_reg <= active;
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = ~ack_reg;
   assign move_done = done_reg;
   assign move_rdata = mrdata_reg;
   assign p1_out = p1_out_reg;
   assign p1_oe = p1_oe_reg;
   assign p2_out = p2_out_reg;
   assign p2_oe = p2_oe_reg;
   assign phi_out = phi_out_reg;
   assign phi_oe = phi_oe_reg;
   assign latch_strobe = ale_reg;
   assign rd_b = rd_b_reg;
   assign wr_b = wr_b_reg;
   assign strobe_oe = soe_reg;
   assign pins_claimed = claim_reg;
endmodule : external_memory_if
`default_nettype wire

// ==== test/external_memory_if_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module external_memory_if_properties (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic move_done,
   input wire logic [7:0] p1_oe,
   input wire logic latch_strobe,
   input wire logic rd_b,
   input wire logic wr_b,
   input wire logic pins_claimed
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Pin ownership, driver direction and handshakes
   chk_claim_active: assert property
      ((!rd_b || !wr_b || latch_strobe) |-> pins_claimed)
      else $error("strobe outside a claimed move");
   chk_read_float: assert property (!rd_b |-> p1_oe == 8'h00)
      else $error("data pins driven during read");
   chk_write_data: assert property (!wr_b |-> p1_oe == 8'hFF)
      else $error("data pins not driven at write");
   chk_addr_phase: assert property
      (latch_strobe |-> p1_oe == 8'hFF && rd_b && wr_b)
      else $error("address phase disturbed");
   chk_pins_back: assert property (move_done |=> !pins_claimed)
      else $error("pins held after move");
   chk_done_single: assert property (move_done |=> !move_done)
      else $error("done longer than one cycle");
   chk_ack_bound: assert property
      ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
      else $error("bus request not answered");
   chk_ack_single: assert property
      (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   cover property (!wr_b);
   cover property (!rd_b);
   cover property ($fell(latch_strobe));
endmodule : external_memory_if_properties
bind external_memory_if external_memory_if_properties i_external_memory_if_properties (.*);
`default_nettype wire

// ==== test/external_memory_if_sram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module external_memory_if_sram_model (
   input wire logic sys_clk,
   input wire logic split,
   input wire logic [7:0] p1_out,
   input wire logic [7:0] p2_out,
   input wire logic [7:0] phi_out,
   input wire logic latch_strobe,
   input wire logic rd_b,
   input wire logic wr_b,
   output logic [7:0] p1_in,
   output logic [7:0] hi_seen,
   output logic [7:0] lo_seen,
   output int wr_count = 0
);
   logic [7:0] mem [256];
   logic [7:0] held;
   logic [7:0] last = 8'h00;
   wire logic [7:0] lo = split ? p2_out : held;
   // Strobe pin is dedicated here, so no crossbar skip is needed
   // Follows the pins while strobe is high, frozen once it falls;
   // clocked so the fall and the pin change cannot race
   always @(posedge sys_clk) if (latch_strobe) held <= p1_out;
   // Drives only in the read strobe, else a toggling pattern
   assign p1_in = !rd_b ? mem[lo] : ~last;
   always @(posedge sys_clk) last <= p1_in;
   // Record address and data seen at each strobe
   always @(posedge sys_clk) begin
      if (!rd_b || !wr_b) begin
         hi_seen <= phi_out;
         lo_seen <= lo;
      end
      if (!wr_b) begin
         mem[lo] <= p1_out;
         wr_count <= wr_count + 1;
      end
   end
endmodule : external_memory_if_sram_model
`default_nettype wire

// ==== test/external_memory_if_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module external_memory_if_bench;
   import external_memory_if_pkg::*;
   logic sys_clk = 1'b0, rst_b = 1'b0, split = 1'b0;
   logic avs_read = 1'b0, avs_write = 1'b0, move_req = 1'b0;
   logic move_write = 1'b0, move_wide = 1'b0;
   logic [7:0] avs_address = 8'h00, move_wdata = 8'h00;
   logic [15:0] move_addr = 16'h0000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic avs_waitrequest, move_done, latch_strobe, rd_b, wr_b;
   logic strobe_oe, pins_claimed;
   logic [7:0] move_rdata, p1_in, p1_out, p1_oe, p2_out, p2_oe;
   logic [7:0] phi_out, phi_oe, hi_seen, lo_seen;
   int wr_count, n, ale_cnt, err_count = 0, n_tests = 0, cycles = 0;
   external_memory_if i_external_memory_if (.*);
   external_memory_if_sram_model i_external_memory_if_sram_model (.*);
   initial forever #50 sys_clk = ~sys_clk;
   // Strobe high time, and a watchdog against hangs
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (latch_strobe === 1'b1) ale_cnt <= ale_cnt + 1;
      if (cycles == 5000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // Request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   // One move; n counts each cycle after the request cycle up to and including done
   task automatic mv(input logic wr, input logic wide,
         input logic [15:0] a, input logic [7:0] d);
      ale_cnt = 0;
      @(posedge sys_clk);
      move_req <= 1'b1;
      move_write <= wr;
      move_wide <= wide;
      move_addr <= a;
      move_wdata <= d;
      @(posedge sys_clk);
      move_req <= 1'b0;
      n = 1;
      @(negedge sys_clk);
      while (move_done !== 1'b1) begin
         n++;
         @(negedge sys_clk);
      end
   endtask : mv
   task automatic t_reset();
      bus(1'b0, PAGE_OFFSET, 32'h0);
      chk(q, 32'h00);
      bus(1'b0, CONFIG_OFFSET, 32'h0);
      chk(q, 32'h03);
      bus(1'b0, 8'h10, 32'h0);
      chk(q, 32'h00);
   endtask : t_reset
   task automatic t_shared();
      for (int w = 0; w < 4; w++) begin
         bus(1'b1, CONFIG_OFFSET, 32'h0C + w);
         mv(1'b1, 1'b1, 16'h2040 + w, 8'hA0 + w);
         chk(n, 2 * (w + 1) + 2);
         chk(ale_cnt, w + 1);
         chk({hi_seen, lo_seen}, 16'h2040 + w);
         mv(1'b0, 1'b1, 16'h2040 + w, 8'h00);
         chk(move_rdata, 8'hA0 + w);
      end
   endtask : t_shared
   task automatic t_split();
      split = 1'b1;
      bus(1'b1, PAGE_OFFSET, 32'h12);
      bus(1'b1, PORT_OUT_OFFSET, 32'h5AFF);
      bus(1'b1, CONFIG_OFFSET, 32'h18);
      mv(1'b1, 1'b0, 16'h0034, 8'h55);
      chk(n, 2);
      chk({hi_seen, lo_seen}, 16'h1234);
      bus(1'b1, CONFIG_OFFSET, 32'h14);
      mv(1'b1, 1'b0, 16'h0035, 8'h56);
      chk({hi_seen, lo_seen}, 16'h5A35);
      chk(phi_out, 8'h5A);
      chk({p2_oe, phi_oe, p1_oe, 7'h00, strobe_oe}, 32'hFFFFFF00);
      bus(1'b1, CONFIG_OFFSET, 32'h1C);
      mv(1'b0, 1'b0, 16'h0034, 8'h00);
      chk({hi_seen, move_rdata}, 16'h5A55);
   endtask : t_split
   task automatic t_alias();
      int c;
      c = wr_count;
      bus(1'b1, CONFIG_OFFSET, 32'h10);
      mv(1'b1, 1'b1, 16'h1234, 8'h77);
      chk(n, 1);
      mv(1'b0, 1'b1, 16'h0634, 8'h00);
      chk(move_rdata, 8'h77);
      bus(1'b1, CONFIG_OFFSET, 32'h14);
      mv(1'b1, 1'b1, 16'h03FF, 8'h66);
      chk(wr_count, c);
      mv(1'b1, 1'b1, 16'h0400, 8'h65);
      chk({hi_seen, lo_seen}, 16'h0400);
   endtask : t_alias
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_shared();
      t_split();
      t_alias();
      end_of_test();
   end
endmodule : external_memory_if_bench
`default_nettype wire
